// File: core/pwr_state_params.svh
/*
 * Timing counts and encodings shared by the power-state controller.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef PWR_STATE_PARAMS_SVH
`define PWR_STATE_PARAMS_SVH

// Bit of the power-down control register that forces power-down
`define PD_REG_BIT 3
// Register offset holding the power-down bit
`define PD_REG_OFFSET 8'h09
// Cycles the internal reset pulse is held after an enable rise
`define EN_RESET_CYCLES 4'h4
// Reset value of the software power-down bit
`define PD_BIT_RESET 1'b0

`endif

// File: core/pwr_state_pkg.sv
/*
 * Types for the power-state controller.
 * Assumes the params header is compiled alongside.
 */
package pwr_state_pkg;
    // Operating states, one-hot
    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_PDOWN   = 4'b0010,
        ST_STANDBY = 4'b0100,
        ST_NORMAL  = 4'b1000
    } pwr_state_t;
endpackage

// File: core/pin_sync.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes one system clock; enable freezes both stages.
 */
`timescale 1ns/1ps
module pin_sync (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic async_i,
    output logic sync_o
);
    // Both stages in one state word
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    // First stage feeds only the second
    always_comb begin
        nxt_state = state_ff;
        nxt_state.meta = async_i;
        nxt_state.stable = state_ff.meta;
    end

    // Synchronous reset to low
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= '0;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
        end
    end

    assign sync_o = state_ff.stable;
endmodule

// File: core/retimer_power_state_control.sv
/*
 * Power-state controller for a link retimer: chooses off, power-down,
 * standby or normal from the enable pin, sink hot-plug, a software
 * power-down bit and clock detection; gates lane, DDC, audio return
 * and control port enables; mirrors hot-plug to the source side.
 * Assumes pins are asynchronous; write strobe and clock-valid come
 * from logic on sys_clk_i.
 */
`timescale 1ns/1ps
`include "pwr_state_params.svh"
module retimer_power_state_control (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic enable_pin_i,
    input wire logic sink_hotplug_in_i,
    input wire logic signal_detect_gate_i,
    input wire logic clk_valid_i,
    input wire logic redriver_mode_i,
    input wire logic pd_wr_i,
    input wire logic [7:0] pd_wr_addr_i,
    input wire logic [7:0] pd_wr_data_i,
    output logic source_hotplug_out_o,
    output logic clk_lane_rx_en_o,
    output logic data_lane_inputs_en_o,
    output logic data_lane_outputs_en_o,
    output logic ddc_en_o,
    output logic arc_en_o,
    output logic local_control_port_en_o,
    output logic soft_reset_o,
    output logic pd_bit_o,
    output logic [3:0] state_o
);
    // Timing overview for users of this block:
    // Pin levels reach the state word three enabled edges after they move,
    // two in the synchroniser and one in the state register.
    // Same-clock inputs (clock valid, mode, signal detect) take one edge.
    // Everything freezes while clk_en_i is low, synchroniser included,
    // so a pin that toggles during a freeze may be missed entirely.
    // Trade-off: one extra flop per output keeps every pin glitch free,
    // at the price of one cycle of latency on every enable.
    // Limitation: no debounce on the pins; a noisy enable pin restarts
    // the internal reset pulse on every clean rising edge it shows.
    // Whole controller state
    typedef struct packed {
        pwr_state_pkg::pwr_state_t st;
        logic en_prev;
        logic pd_bit;
        logic [3:0] rst_cnt;
        logic source_hotplug_out;
        logic clk_rx;
        logic data_rx;
        logic data_tx;
        logic ddc;
        logic arc;
        logic ctl;
        logic srst;
    } ctl_state_t;

    ctl_state_t state_ff;
    ctl_state_t nxt_state;
    logic en_sync; // Synchronised enable pin
    logic hpd_sync; // Synchronised sink hot-plug

    // Both pins are asynchronous to sys_clk_i.
    // Two flops each keep metastability out of the decode below.
    // The enable edge is taken only from the synchronised level,
    // never from the raw pin, so a runt pulse cannot half-reset.
    // Reset of the synchronisers is low, which matches the idle
    // level of both pins and avoids a false edge after reset.
    // synchronise enable
    pin_sync en_sync_u (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(enable_pin_i),
        .sync_o(en_sync)
    );

    pin_sync hpd_sync_u (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(sink_hotplug_in_i),
        .sync_o(hpd_sync)
    );

    // Priority of the state choice, highest first:
    // Enable low wins over everything and turns the port off too.
    // Software bit, missing hot-plug or reset pulse give power-down.
    // Retimer without a clock waits in standby on the clock lane.
    // Redriver runs even without a clock, so it never waits.
    // Kept as a function so the priority reads in one place and
    // can be reused if a second decode point is ever needed.
    // Decides target state from qualified inputs
    function automatic pwr_state_pkg::pwr_state_t pick_state(
        input logic en, input logic hpd, input logic pd,
        input logic clk_ok, input logic redrv);
        pick_state = pwr_state_pkg::ST_NORMAL;
        if (!en) begin
            pick_state = pwr_state_pkg::ST_OFF;
        end else if (pd || !hpd) begin
            pick_state = pwr_state_pkg::ST_PDOWN;
        end else if (!clk_ok && !redrv) begin
            pick_state = pwr_state_pkg::ST_STANDBY;
        end
    endfunction

    // Next-state and output decode
    always_comb begin
        nxt_state = state_ff;
        nxt_state.en_prev = en_sync;
        nxt_state.srst = 1'b0;
        // Reset pulse counter:
        // Loaded on the synchronised enable rise, counts down to zero.
        // The pulse stands while the count is non-zero, so its length
        // equals the load value in enabled cycles.
        // A new rise during the pulse reloads it; the pulse then
        // simply stretches, which is the safe direction.
        // The write port is refused while the pulse stands, so the
        // controlling side must rewrite its settings afterwards.
        // enable rise resets
        if (en_sync && !state_ff.en_prev) begin
            nxt_state.rst_cnt = `EN_RESET_CYCLES;
        end else if (state_ff.rst_cnt != 4'h0) begin
            nxt_state.rst_cnt = state_ff.rst_cnt - 4'h1;
        end
        if (nxt_state.rst_cnt != 4'h0) begin
            nxt_state.srst = 1'b1;
        end
        if (!en_sync || nxt_state.srst) begin
            // Settings are lost while off or resetting
            nxt_state.pd_bit = `PD_BIT_RESET;
        end else if (pd_wr_i && pd_wr_addr_i == `PD_REG_OFFSET) begin
            nxt_state.pd_bit = pd_wr_data_i[`PD_REG_BIT];
        end
        // Hold power-down through the reset pulse
        nxt_state.st = pick_state(en_sync, hpd_sync,
            nxt_state.pd_bit | nxt_state.srst, clk_valid_i, redriver_mode_i);
        nxt_state.source_hotplug_out = hpd_sync;
        nxt_state.clk_rx = 1'b0;
        nxt_state.data_rx = 1'b0;
        nxt_state.data_tx = 1'b0;
        nxt_state.ddc = 1'b0;
        nxt_state.arc = 1'b0;
        nxt_state.ctl = 1'b1;
        // Path enables follow the state chosen this cycle.
        // Defaults above are the power-down set: only the port on.
        // Off then drops the port, the others add what they need, so a missing branch
        // fails towards power-down rather than towards driving lanes.
        // Codes are one-hot and the choice is always one of four,
        // so no default branch is needed here.
        unique case (nxt_state.st)
            pwr_state_pkg::ST_OFF: begin
                nxt_state.ctl = 1'b0;
            end
            pwr_state_pkg::ST_PDOWN: begin
                nxt_state.ctl = 1'b1;
            end
            pwr_state_pkg::ST_STANDBY: begin
                nxt_state.clk_rx = 1'b1;
                nxt_state.ddc = 1'b1;
                nxt_state.arc = 1'b1;
            end
            pwr_state_pkg::ST_NORMAL: begin
                nxt_state.clk_rx = 1'b1;
                nxt_state.ddc = 1'b1;
                nxt_state.arc = 1'b1;
                // Redriver passes data whether or not gated
                nxt_state.data_rx = signal_detect_gate_i | redriver_mode_i;
                nxt_state.data_tx = signal_detect_gate_i | redriver_mode_i;
            end
        endcase
    end

    // Reset lands in off with every path disabled, the same as an
    // enable pin held low, so nothing drives until pins are seen.
    // Clock enable low freezes the whole word, outputs included.
    // State register; sync reset lands in off
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= '{st: pwr_state_pkg::ST_OFF, default: '0};
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
        end
    end

    // No logic between the state word and the pins, so enables
    // cannot glitch while the next state is being decoded.
    // A low enable means the lane is left at high impedance.
    // All outputs straight from flops
    assign source_hotplug_out_o = state_ff.source_hotplug_out;
    assign clk_lane_rx_en_o = state_ff.clk_rx;
    assign data_lane_inputs_en_o = state_ff.data_rx;
    assign data_lane_outputs_en_o = state_ff.data_tx;
    assign ddc_en_o = state_ff.ddc;
    assign arc_en_o = state_ff.arc;
    assign local_control_port_en_o = state_ff.ctl;
    assign soft_reset_o = state_ff.srst;
    assign pd_bit_o = state_ff.pd_bit;
    assign state_o = state_ff.st;
endmodule

// File: testbench/pwr_state_sva.sv
/* Assertions for the power-state controller.
   Sees only the top module's ports; one clock, synchronous reset. */
`timescale 1ns/1ps
module pwr_state_sva (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic enable_pin_i,
    input wire logic sink_hotplug_in_i,
    input wire logic clk_valid_i,
    input wire logic redriver_mode_i,
    input wire logic source_hotplug_out_o,
    input wire logic data_lane_outputs_en_o,
    input wire logic ddc_en_o,
    input wire logic local_control_port_en_o,
    input wire logic soft_reset_o,
    input wire logic pd_bit_o,
    input wire logic [3:0] state_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Pins are judged only once they have been steady past the synchroniser
    sequence en_rise; !enable_pin_i ##1 enable_pin_i [*3]; endsequence
    sequence hp_still; $stable(sink_hotplug_in_i) [*4]; endsequence
    a_off_quiet: assert property (
        state_o == 4'h1 |-> !local_control_port_en_o && !ddc_en_o) else $error("off paths on");
    a_pdown_ctl: assert property (
        state_o == 4'h2 |-> local_control_port_en_o && !ddc_en_o && !data_lane_outputs_en_o)
        else $error("pdown paths wrong");
    a_standby_mix: assert property (
        state_o == 4'h4 |-> ddc_en_o && !data_lane_outputs_en_o) else $error("standby paths");
    a_hp_mirror: assert property (
        hp_still |-> source_hotplug_out_o == sink_hotplug_in_i) else $error("hotplug copy");
    a_rise_reset: assert property (
        en_rise |-> ##[0:2] soft_reset_o && !pd_bit_o) else $error("no reset on enable");
    a_reset_len: assert property (
        $rose(soft_reset_o) |-> soft_reset_o [*4] ##1 !soft_reset_o) else $error("reset length");
    a_retimer_clk: assert property (
        !$past(clk_valid_i) && !$past(redriver_mode_i) |-> state_o != 4'h8) else $error("no clk");
    a_redrv_lanes: assert property (
        state_o == 4'h8 && $past(redriver_mode_i) |-> data_lane_outputs_en_o) else $error("redrv");
endmodule
bind retimer_power_state_control pwr_state_sva pwr_state_sva_i (.*);

// File: testbench/sink_end_model.sv
/* Sink end: follows the hot-plug request after a short or long lag.
   Assumes the bench clock; the lag counts its rising edges. */
`timescale 1ns/1ps
module sink_end_model (
    input wire logic clk_i,
    input wire logic want_i,
    input wire logic slow_i,
    output logic hotplug_o
);
    logic [2:0] lag_ff = 3'h0; // Cycles spent waiting
    initial hotplug_o = 1'b0;
    // Slow mode waits five cycles, like a sluggish sink
    always @(posedge clk_i) begin
        lag_ff <= (want_i == hotplug_o) ? 3'h0 : lag_ff + 3'h1;
        if (want_i != hotplug_o && lag_ff >= (slow_i ? 3'h5 : 3'h0)) hotplug_o <= want_i;
    end
endmodule

// File: testbench/tb.sv
/* Bench: pins change at falling edges, the sink model drives hot-plug.
   Expected states are queued and popped whenever state_o moves. */
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, enable_pin_i = 0, pd_wr_i = 0;
    logic signal_detect_gate_i = 0, clk_valid_i = 0, redriver_mode_i = 0;
    logic [7:0] pd_wr_addr_i = 8'h00, pd_wr_data_i = 8'h00;
    logic sink_hotplug_in_i, source_hotplug_out_o, clk_lane_rx_en_o, data_lane_inputs_en_o;
    logic data_lane_outputs_en_o, ddc_en_o, arc_en_o, local_control_port_en_o, soft_reset_o;
    logic pd_bit_o, want = 0, slow = 0;
    logic [3:0] state_o, st_seen = 4'h1, last = 4'h1;
    logic [3:0] q_st[$];
    logic [31:0] rv;
    int fails = 0, compares = 0, cyc = 0, seed = 32'h148b0dea;
    logic gate_q = 0; // Lane gate as the design sampled it
    logic [5:0] en_exp; // Expected {clk_rx, data_in, data_out, ddc, arc, ctl}
    always @(posedge sys_clk_i) gate_q <= signal_detect_gate_i | redriver_mode_i;
    always #5 sys_clk_i = ~sys_clk_i;
    retimer_power_state_control retimer_power_state_control_i (.*);
    sink_end_model sink_end_model_i (.clk_i(sys_clk_i), .want_i(want), .slow_i(slow),
        .hotplug_o(sink_hotplug_in_i));
    task automatic chk_st(input logic [3:0] exp);
        compares++;
        if (state_o !== exp) begin
            fails++;
            $display("[ERR] state_o exp %h got %h", exp, state_o);
        end
    endtask
    task automatic chk_en(input logic [5:0] exp);
        compares++;
        if ({clk_lane_rx_en_o, data_lane_inputs_en_o, data_lane_outputs_en_o, ddc_en_o,
            arc_en_o, local_control_port_en_o} !== exp) begin
            fails++;
            $display("[ERR] path_enables exp %h got %h", exp, {clk_lane_rx_en_o,
                data_lane_inputs_en_o, data_lane_outputs_en_o, ddc_en_o, arc_en_o,
                local_control_port_en_o});
        end
    endtask
    // Queue a state only when it differs from the last one queued
    task automatic go(input logic [3:0] s);
        if (s !== last) q_st.push_back(s);
        last = s;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        pd_wr_i = 1;
        pd_wr_addr_i = a;
        pd_wr_data_i = d;
        tick(1);
        pd_wr_i = 0;
    endtask
    task automatic test_done;
        if (q_st.size() != 0) fails++;
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watch outputs at falling edges, where they are settled
    always @(negedge sys_clk_i) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            test_done();
        end else begin
            if (!sys_rst_i && state_o !== st_seen) chk_st(q_st.size() ? q_st.pop_front() : 4'hx);
            st_seen = state_o;
            case (state_o)
                4'h2: en_exp = 6'h01;
                4'h4: en_exp = 6'h27;
                4'h8: en_exp = gate_q ? 6'h3f : 6'h27;
                default: en_exp = 6'h00;
            endcase
            if (!sys_rst_i) chk_en(en_exp);
        end
    end
    initial begin
        tick(2);
        sys_rst_i = 0;
        enable_pin_i = 1;
        go(4'h2);
        tick(10);
        want = 1;
        go(4'h4);
        tick(10);
        clk_valid_i = 1;
        go(4'h8);
        tick(5);
        wr(8'h0a, 8'h08);
        tick(5);
        go(4'h2);
        go(4'h8);
        wr(8'h09, 8'h08);
        wr(8'h09, 8'h00);
        tick(5);
        repeat (40) begin
            rv = $random(seed);
            {signal_detect_gate_i, redriver_mode_i, clk_valid_i} = rv[2:0];
            go((rv[0] | rv[1]) ? 4'h8 : 4'h4);
            tick(4);
        end
        clk_valid_i = 1;
        go(4'h8);
        go(4'h2);
        wr(8'h09, 8'h08);
        go(4'h1);
        enable_pin_i = 0;
        tick(8);
        slow = 1;
        want = 0;
        tick(12);
        enable_pin_i = 1;
        go(4'h2);
        tick(10);
        want = 1;
        go(4'h8);
        tick(14);
        want = 0;
        go(4'h2);
        tick(14);
        test_done();
    end
endmodule
